// ==== cbc_bus_ctl.sv ====
// cbc_bus_ctl: external bus and control pins of the cpu core
//
// How it works
// - reset high two cycles gives sync reset
// - not-ready input adds wait states while low
// - maskable request at instruction end, enabled
// - nmi outranks maskable, ignores enable flag
// - nmi service resumes fetching at 0066h
// - bus hold outranks nmi, taken per cycle
// - hold releases address, data and strobes
// - grant only after release; master waits
// - first-cycle output with memory request on fetch
// - first-cycle output with i/o request on ack
// - 16-bit address output with drive enable
// - split 8-bit data buses with drive enable
// - memory request only with valid address
// - i/o request only with valid port address
// - synchronous except the async power-on reset, no internal tri-states
// - read strobe while core wants data
// - write strobe only with valid data out
// - refresh strobe with memory request, 7 bits
// - stopped output low from halt to interrupt
`timescale 1ns/1ps
`default_nettype none
module cbc_bus_ctl #(
  parameter int ADDR_W = cbc_pkg::ADDR_W,
  parameter int DATA_W = cbc_pkg::DATA_W
) (
  // clock and resets
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic reset_in,
  output logic core_rst_out,
  // machine cycle requests from the core
  input wire logic req_valid_in,
  input wire cbc_pkg::cbc_kind_t req_kind_in,
  input wire logic [ADDR_W-1:0] req_addr_in,
  input wire logic [DATA_W-1:0] req_wdata_in,
  input wire logic req_last_in,
  output logic req_ready_out,
  output logic done_out,
  output logic [DATA_W-1:0] rdata_out,
  // interrupt and halt exchange with the core
  input wire logic ie_in,
  input wire logic halt_in,
  output logic irq_take_out,
  output logic irq_nmi_out,
  output logic [ADDR_W-1:0] irq_vector_out,
  // interrupt and hold pins
  input wire logic int_n_in,
  input wire logic nmi_n_in,
  input wire logic busreq_n_in,
  output logic busak_n_out,
  input wire logic wait_n_in,
  // address and data pins
  output logic [ADDR_W-1:0] addr_out,
  output logic addr_drv_out,
  input wire logic [DATA_W-1:0] data_in,
  output logic [DATA_W-1:0] data_out,
  output logic data_drv_out,
  // strobe pins with their drive enables
  output logic opcode_fetch_cycle_out,
  output logic mreq_n_out,
  output logic mreq_drv_out,
  output logic ioreq_n_out,
  output logic ioreq_drv_out,
  output logic rd_n_out,
  output logic rd_drv_out,
  output logic wr_n_out,
  output logic wr_drv_out,
  output logic rfsh_n_out,
  output logic halt_n_out
);

  // bus sequencer states
  typedef enum logic [6:0] {
    CBC_IDLE = 7'b0000001, // between machine cycles
    CBC_T1 = 7'b0000010,   // address out, strobes on
    CBC_T2 = 7'b0000100,   // wait sampling
    CBC_T3 = 7'b0001000,   // data capture
    CBC_RF = 7'b0010000,   // refresh after fetch
    CBC_REL = 7'b0100000,  // releasing the bus
    CBC_HOLD = 7'b1000000  // bus granted away
  } cbc_state_t;

  cbc_state_t state_q; // sequencer state
  cbc_state_t state_d; // its next value
  cbc_pkg::cbc_kind_t kind_q; // kind of running cycle
  logic [ADDR_W-1:0] addr_q; // address on the pins
  logic [DATA_W-1:0] wdata_q; // write data on the pins
  logic [DATA_W-1:0] rdata_q; // captured read data
  logic last_q; // running cycle ends the instruction
  logic done_q; // one-cycle done pulse
  logic boundary_q; // at an instruction boundary
  logic halted_q; // halt executed, awaiting interrupt
  logic [cbc_pkg::RFSH_W-1:0] rfsh_q; // refresh counter
  logic take_q; // registered interrupt accept
  logic nmi_q; // accepted one was nmi
  logic [ADDR_W-1:0] vec_q; // restart address
  logic rst; // qualified synchronous reset
  logic in_cyc; // inside t1..t3
  logic hold_req; // bus hold asked for
  logic accept; // request taken this cycle
  logic cyc_end; // machine cycle finishes this cycle
  logic fetch_q; // running cycle is an opcode fetch

  // upper address bits during refresh
  localparam int RFSH_HI = ADDR_W - cbc_pkg::RFSH_W;

  // link to the interrupt arbiter
  cbc_irq_if irq ();

  // external reset qualifier
  cbc_rst_qual u_rst (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .reset_in(reset_in),
    .sync_rst_out(rst)
  );

  // interrupt priority and nmi latch
  cbc_irq_arb u_arb (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .rst_in(rst),
    .int_n_in(int_n_in),
    .nmi_n_in(nmi_n_in),
    .irq(irq.arb)
  );

  // core side sees the qualified reset
  assign core_rst_out = rst;

  // common decodes
  assign in_cyc = (state_q == CBC_T1) || (state_q == CBC_T2)
    || (state_q == CBC_T3);
  assign hold_req = !busreq_n_in;
  assign fetch_q = (kind_q == cbc_pkg::CBC_FETCH);
  assign cyc_end = ((state_q == CBC_T3) && !fetch_q)
    || (state_q == CBC_RF);

  // arbiter inputs
  assign irq.boundary = boundary_q;
  assign irq.idle = (state_q == CBC_IDLE);
  assign irq.hold_want = hold_req;
  assign irq.ie = ie_in;

  // new cycle only when idle, no hold, no interrupt
  assign req_ready_out = (state_q == CBC_IDLE) && !hold_req
    && !irq.take && !halted_q;
  assign accept = req_ready_out && req_valid_in;

  // next state of the bus sequencer
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      CBC_IDLE: begin
        // hold between cycles, else start a cycle
        if (hold_req) begin
          state_d = CBC_REL;
        end else if (accept) begin
          state_d = CBC_T1;
        end
      end
      CBC_T1: begin
        state_d = CBC_T2;
      end
      CBC_T2: begin
        // stay while the addressed device is not ready
        if (wait_n_in) begin
          state_d = CBC_T3;
        end
      end
      CBC_T3: begin
        // fetch is followed by a refresh slot
        if (fetch_q) begin
          state_d = CBC_RF;
        end else if (hold_req) begin
          state_d = CBC_REL;
        end else begin
          state_d = CBC_IDLE;
        end
      end
      CBC_RF: begin
        // hold recognised at machine cycle end
        state_d = hold_req ? CBC_REL : CBC_IDLE;
      end
      CBC_REL: begin
        // drivers are off now, grant next
        state_d = CBC_HOLD;
      end
      CBC_HOLD: begin
        // give the bus back when request drops
        if (!hold_req) begin
          state_d = CBC_IDLE;
        end
      end
      default: begin
        state_d = CBC_IDLE;
      end
    endcase
  end

  // sequencer state register, sync reset only acts on clock
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_q <= CBC_IDLE;
    end else if (rst) begin
      state_q <= CBC_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // cycle kind, last flag and write data latched on accept
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      kind_q <= cbc_pkg::CBC_MRD;
      last_q <= 1'b0;
      wdata_q <= cbc_pkg::DATA_RST;
    end else if (rst) begin
      kind_q <= cbc_pkg::CBC_MRD;
      last_q <= 1'b0;
      wdata_q <= cbc_pkg::DATA_RST;
    end else if (accept) begin
      kind_q <= req_kind_in;
      last_q <= req_last_in;
      wdata_q <= req_wdata_in;
    end
  end

  // address register: request address, then refresh address
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      addr_q <= cbc_pkg::ADDR_RST;
    end else if (rst) begin
      addr_q <= cbc_pkg::ADDR_RST;
    end else if (accept) begin
      addr_q <= req_addr_in;
    end else if ((state_q == CBC_T3) && fetch_q) begin
      addr_q <= {{RFSH_HI{1'b0}}, rfsh_q};
    end
  end

  // refresh counter steps after each refresh slot
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rfsh_q <= cbc_pkg::RFSH_RST;
    end else if (rst) begin
      rfsh_q <= cbc_pkg::RFSH_RST;
    end else if (state_q == CBC_RF) begin
      rfsh_q <= rfsh_q + 1'b1;
    end
  end

  // read data capture and done pulse at the end of t3
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rdata_q <= cbc_pkg::DATA_RST;
      done_q <= 1'b0;
    end else if (rst) begin
      rdata_q <= cbc_pkg::DATA_RST;
      done_q <= 1'b0;
    end else begin
      done_q <= (state_q == CBC_T3);
      // read data gated onto data_in by the read strobe
      if ((state_q == CBC_T3) && cbc_pkg::is_rd(kind_q)) begin
        rdata_q <= data_in;
      end
    end
  end

  // instruction boundary: set by last cycle, cleared on use
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      boundary_q <= 1'b1;
    end else if (rst) begin
      boundary_q <= 1'b1;
    end else if (cyc_end && last_q) begin
      boundary_q <= 1'b1;
    end else if (accept || irq.take) begin
      boundary_q <= 1'b0;
    end
  end

  // halt state: halt wins over a same-cycle interrupt take
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      halted_q <= 1'b0;
    end else if (rst) begin
      halted_q <= 1'b0;
    end else if (halt_in) begin
      halted_q <= 1'b1;
    end else if (irq.take) begin
      halted_q <= 1'b0;
    end
  end

  // interrupt accept reported to the core
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      take_q <= 1'b0;
      nmi_q <= 1'b0;
      vec_q <= cbc_pkg::ADDR_RST;
    end else if (rst) begin
      take_q <= 1'b0;
      nmi_q <= 1'b0;
      vec_q <= cbc_pkg::ADDR_RST;
    end else begin
      take_q <= irq.take;
      if (irq.take) begin
        nmi_q <= irq.take_nmi;
        // nmi restarts at the fixed vector
        vec_q <= irq.take_nmi ? cbc_pkg::NMI_VECTOR
          : cbc_pkg::ADDR_RST;
      end
    end
  end

  // core side outputs
  assign done_out = done_q;
  assign rdata_out = rdata_q;
  assign irq_take_out = take_q;
  assign irq_nmi_out = nmi_q;
  assign irq_vector_out = vec_q;

  // address and data pins, released in hold
  assign addr_out = addr_q;
  assign addr_drv_out = !(state_q == CBC_REL)
    && !(state_q == CBC_HOLD);
  assign data_out = wdata_q;
  // data is driven only during write cycles
  assign data_drv_out = in_cyc
    && cbc_pkg::is_wr(kind_q);

  // strobes: all enables follow the address enable
  assign mreq_n_out = !((in_cyc && cbc_pkg::is_mem(kind_q))
    || (state_q == CBC_RF));
  assign ioreq_n_out = !(in_cyc
    && cbc_pkg::is_io(kind_q));
  assign rd_n_out = !(in_cyc && cbc_pkg::is_rd(kind_q));
  assign wr_n_out = !(in_cyc && cbc_pkg::is_wr(kind_q));
  assign rfsh_n_out = !(state_q == CBC_RF);
  assign mreq_drv_out = addr_drv_out;
  assign ioreq_drv_out = addr_drv_out;
  assign rd_drv_out = addr_drv_out;
  assign wr_drv_out = addr_drv_out;

  // first-cycle output on fetch and acknowledge
  assign opcode_fetch_cycle_out = in_cyc
    && cbc_pkg::is_m1(kind_q);

  // grant only once the drivers are already off
  assign busak_n_out = !(state_q == CBC_HOLD);

  // stopped indicator
  assign halt_n_out = !halted_q;

endmodule : cbc_bus_ctl
`default_nettype wire

// ==== cbc_pkg.sv ====
// cbc_pkg: shared constants, cycle kinds and decode helpers
package cbc_pkg;

  // bus widths
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  // refresh address width on the low address lines
  localparam int RFSH_W = 7;
  // non-maskable interrupt restart address
  localparam logic [15:0] NMI_VECTOR = 16'h0066;
  // cycles the external reset must be held high
  localparam int RESET_HOLD_CYC = 2;
  // reset values
  localparam logic [15:0] ADDR_RST = 16'h0000;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [6:0] RFSH_RST = 7'h00;

  // machine cycle kinds asked for by the core
  typedef enum logic [2:0] {
    CBC_FETCH = 3'h0, // opcode fetch
    CBC_MRD = 3'h1,   // memory read
    CBC_MWR = 3'h2,   // memory write
    CBC_IORD = 3'h3,  // i/o read
    CBC_IOWR = 3'h4,  // i/o write
    CBC_INTA = 3'h5   // interrupt acknowledge
  } cbc_kind_t;

  // cycle drives the memory request strobe
  function automatic logic is_mem(input cbc_kind_t k);
    is_mem = (k == CBC_FETCH) || (k == CBC_MRD) || (k == CBC_MWR);
  endfunction : is_mem

  // cycle drives the i/o request strobe
  function automatic logic is_io(input cbc_kind_t k);
    is_io = (k == CBC_IORD) || (k == CBC_IOWR) || (k == CBC_INTA);
  endfunction : is_io

  // cycle reads data from the bus
  function automatic logic is_rd(input cbc_kind_t k);
    is_rd = (k == CBC_FETCH) || (k == CBC_MRD) || (k == CBC_IORD)
      || (k == CBC_INTA);
  endfunction : is_rd

  // cycle writes data to the bus
  function automatic logic is_wr(input cbc_kind_t k);
    is_wr = (k == CBC_MWR) || (k == CBC_IOWR);
  endfunction : is_wr

  // cycle raises the first-machine-cycle output
  function automatic logic is_m1(input cbc_kind_t k);
    is_m1 = (k == CBC_FETCH) || (k == CBC_INTA);
  endfunction : is_m1

endpackage : cbc_pkg

// ==== cbc_irq_if.sv ====
// cbc_irq_if: link between cycle control and interrupt arbiter
`timescale 1ns/1ps
`default_nettype none
interface cbc_irq_if;
  logic boundary;  // instruction ended, none started
  logic idle;      // no machine cycle in progress
  logic hold_want; // bus hold request present
  logic ie;        // interrupt enable flip-flop
  logic take;      // accept interrupt now
  logic take_nmi;  // accepted one is non-maskable
  modport ctl (output boundary, idle, hold_want, ie,
    input take, take_nmi);
  modport arb (input boundary, idle, hold_want, ie,
    output take, take_nmi);
endinterface : cbc_irq_if
`default_nettype wire

// ==== cbc_rst_qual.sv ====
// cbc_rst_qual: qualifies the external reset into a sync reset
`timescale 1ns/1ps
`default_nettype none
module cbc_rst_qual #(
  parameter int HOLD_CYC = cbc_pkg::RESET_HOLD_CYC
) (
  // clock and power-on reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // external reset level and qualified result
  input wire logic reset_in,
  output logic sync_rst_out
);
  // consecutive high samples, saturating
  logic [1:0] cnt_q;
  localparam logic [1:0] HOLD = 2'(HOLD_CYC);

  // count while high, restart on any low sample
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cnt_q <= 2'h0;
    end else if (!reset_in) begin
      cnt_q <= 2'h0;
    end else if (cnt_q != HOLD) begin
      cnt_q <= cnt_q + 2'h1;
    end
  end

  // reset acts once held long enough, lasts while held
  assign sync_rst_out = (cnt_q == HOLD) && reset_in;
endmodule : cbc_rst_qual
`default_nettype wire

// ==== cbc_irq_arb.sv ====
// cbc_irq_arb: nmi edge latch and interrupt priority
`timescale 1ns/1ps
`default_nettype none
module cbc_irq_arb (
  // clock and resets
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic rst_in,
  // interrupt pins
  input wire logic int_n_in,
  input wire logic nmi_n_in,
  // link to cycle control
  cbc_irq_if.arb irq
);
  logic nmi_prev_q; // last nmi pin sample
  logic nmi_pend_q; // nmi edge seen, not yet served
  logic nmi_edge;   // falling edge this cycle
  logic int_ok;     // maskable request allowed

  assign nmi_edge = nmi_prev_q && !nmi_n_in;
  // maskable only with the enable flip-flop set
  assign int_ok = !int_n_in && irq.ie;

  // sample nmi pin for edge detection
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      nmi_prev_q <= 1'b1;
    end else if (rst_in) begin
      nmi_prev_q <= 1'b1;
    end else begin
      nmi_prev_q <= nmi_n_in;
    end
  end

  // pending nmi: a new edge wins over the clear
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      nmi_pend_q <= 1'b0;
    end else if (rst_in) begin
      nmi_pend_q <= 1'b0;
    end else if (nmi_edge) begin
      nmi_pend_q <= 1'b1;
    end else if (irq.take && irq.take_nmi) begin
      nmi_pend_q <= 1'b0;
    end
  end

  // accept at instruction end, never against bus hold
  assign irq.take = irq.boundary && irq.idle && !irq.hold_want
    && (nmi_pend_q || int_ok);
  // nmi outranks maskable, enable ignored
  assign irq.take_nmi = nmi_pend_q;
endmodule : cbc_irq_arb
`default_nettype wire

// ==== cbc_bus_ctl_chk.sv ====
// cbc_bus_ctl_chk: concurrent checks on the bus control pins
`timescale 1ns/1ps
`default_nettype none
module cbc_bus_ctl_chk (
  // clock and resets
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic reset_in,
  input wire logic core_rst_out,
  // hold and wait pins
  input wire logic busreq_n_in,
  input wire logic busak_n_out,
  input wire logic wait_n_in,
  // interrupt results
  input wire logic done_out,
  input wire logic irq_take_out,
  input wire logic irq_nmi_out,
  input wire logic [15:0] irq_vector_out,
  // address and data pins
  input wire logic [15:0] addr_out,
  input wire logic addr_drv_out,
  input wire logic [7:0] data_out,
  input wire logic data_drv_out,
  // strobes and their enables
  input wire logic opcode_fetch_cycle_out,
  input wire logic mreq_n_out,
  input wire logic mreq_drv_out,
  input wire logic ioreq_n_out,
  input wire logic ioreq_drv_out,
  input wire logic rd_n_out,
  input wire logic rd_drv_out,
  input wire logic wr_n_out,
  input wire logic wr_drv_out,
  input wire logic rfsh_n_out
);
  // one clock domain, power-on reset disables all
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!resetn_in);

  // two high samples of the reset input give the core reset
  a_rst_qualify: assert property (reset_in ##1 reset_in ##1 reset_in
    |-> core_rst_out) else $error("core reset not raised");
  // a read strobe with wait low stays, or the cycle just ended
  a_wait_stretch: assert property (!reset_in && !wait_n_in
    && !rd_n_out |=> !rd_n_out || done_out) else $error("wait ignored");
  // first-cycle output pairs with exactly one request strobe
  a_fetch_mark: assert property (opcode_fetch_cycle_out
    |-> mreq_n_out != ioreq_n_out) else $error("m1 without strobe");
  // memory and i/o requests never overlap
  a_req_excl: assert property (!mreq_n_out |-> ioreq_n_out)
    else $error("mreq and ioreq together");
  // refresh rides on mreq with the upper nine address bits clear
  a_rfsh_shape: assert property (!rfsh_n_out |-> !mreq_n_out
    && rd_n_out && !opcode_fetch_cycle_out && addr_out[15:7] == 9'h000)
    else $error("bad refresh cycle");
  // data pins driven exactly while writing
  a_data_drive: assert property (data_drv_out == !wr_n_out)
    else $error("data enable off write");
  // write data stands still through the strobe
  a_wdata_hold: assert property (!wr_n_out ##1 !wr_n_out
    |-> $stable(data_out)) else $error("write data moved");
  // granted hold floats every pin that has a drive enable
  a_hold_float: assert property (!busak_n_out |-> !addr_drv_out
    && !data_drv_out && !mreq_drv_out && !ioreq_drv_out && !rd_drv_out
    && !wr_drv_out) else $error("pin driven in hold");
  // grant falls only after a cycle with the bus released
  a_grant_late: assert property ($fell(busak_n_out)
    |-> !$past(addr_drv_out) && !$past(mreq_drv_out))
    else $error("grant before release");
  // grant kept while hold asked for
  a_grant_keep: assert property (!busak_n_out && !busreq_n_in
    |=> !busak_n_out) else $error("grant dropped early");
  // non-maskable service restarts at its fixed vector
  a_nmi_vector: assert property (irq_take_out && irq_nmi_out
    |-> irq_vector_out == 16'h0066) else $error("bad nmi vector");
endmodule : cbc_bus_ctl_chk

bind cbc_bus_ctl cbc_bus_ctl_chk i_cbc_bus_ctl_chk (
  .clk_in(clk_in), .resetn_in(resetn_in), .reset_in(reset_in),
  .core_rst_out(core_rst_out), .busreq_n_in(busreq_n_in),
  .busak_n_out(busak_n_out), .wait_n_in(wait_n_in), .done_out(done_out),
  .irq_take_out(irq_take_out), .irq_nmi_out(irq_nmi_out),
  .irq_vector_out(irq_vector_out), .addr_out(addr_out),
  .addr_drv_out(addr_drv_out), .data_out(data_out),
  .data_drv_out(data_drv_out),
  .opcode_fetch_cycle_out(opcode_fetch_cycle_out),
  .mreq_n_out(mreq_n_out), .mreq_drv_out(mreq_drv_out),
  .ioreq_n_out(ioreq_n_out), .ioreq_drv_out(ioreq_drv_out),
  .rd_n_out(rd_n_out), .rd_drv_out(rd_drv_out), .wr_n_out(wr_n_out),
  .wr_drv_out(wr_drv_out), .rfsh_n_out(rfsh_n_out));
`default_nettype wire

// ==== cbc_mem_model.sv ====
// cbc_mem_model: memory and i/o device with optional wait states
`timescale 1ns/1ps
`default_nettype none
module cbc_mem_model (
  // clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // bus pins seen from the device
  input wire logic [15:0] addr_in,
  input wire logic mreq_n_in,
  input wire logic ioreq_n_in,
  input wire logic rd_n_in,
  input wire logic wr_n_in,
  input wire logic [7:0] wdata_in,
  // not-ready cycles wanted for this transfer, counted from t1
  input wire logic [1:0] nwait_in,
  // answers to the core
  output logic [7:0] rdata_out,
  output logic wait_n_out,
  output logic [7:0] last_wr_out
);
  logic [1:0] cnt_q; // cycles since the strobe fell
  logic [7:0] junk_q; // filler that changes every cycle
  logic act; // a read or write addresses us
  assign act = (!mreq_n_in || !ioreq_n_in) && (!rd_n_in || !wr_n_in);
  // not ready for the first nwait cycles of a transfer
  assign wait_n_out = !(act && cnt_q < nwait_in);
  // data only while read strobe is low and we are ready
  assign rdata_out = (act && !rd_n_in && wait_n_out) ?
    addr_in[7:0] ^ 8'h3C : junk_q;

  // wait counter, filler and write capture
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cnt_q <= 2'h0;
      junk_q <= 8'hA5;
      last_wr_out <= 8'h00;
    end else begin
      junk_q <= junk_q + 8'h3B;
      cnt_q <= (act && cnt_q != 2'h3) ? cnt_q + 2'h1 : (act ? cnt_q : 2'h0);
      // store what the core holds under the write strobe
      if (act && !wr_n_in) begin
        last_wr_out <= wdata_in;
      end
    end
  end
endmodule : cbc_mem_model
`default_nettype wire

// ==== cbc_bus_ctl_tb.sv ====
// cbc_bus_ctl_tb: self-checking bench for the external bus control
`timescale 1ns/1ps
`default_nettype none
module cbc_bus_ctl_tb;
  logic clk_in, resetn_in, reset_in, req_valid_in, req_last_in, ie_in;
  cbc_pkg::cbc_kind_t req_kind_in;
  logic [15:0] req_addr_in, irq_vector_out, addr_out;
  logic [7:0] req_wdata_in, data_in, data_out, rdata_out, last_wr;
  logic halt_in, int_n_in, nmi_n_in, busreq_n_in, wait_n_in, done_out;
  logic core_rst_out, req_ready_out, irq_take_out, irq_nmi_out;
  logic busak_n_out, addr_drv_out, data_drv_out, opcode_fetch_cycle_out;
  logic mreq_n_out, mreq_drv_out, ioreq_n_out, ioreq_drv_out, rd_n_out;
  logic rd_drv_out, wr_n_out, wr_drv_out, rfsh_n_out, halt_n_out;
  logic [1:0] nwait; // cycles the device holds wait low, counted from t1
  logic [18:0] seen; // write, m1, io, address of the running cycle
  logic [26:0] exp_q[$]; // expected cycle results
  logic [16:0] irq_q[$]; // expected interrupt takes
  logic [31:0] r; // random scratch
  int miscompares, tests_run, seed;

  cbc_bus_ctl i_cbc_bus_ctl (.clk_in, .resetn_in, .reset_in, .core_rst_out,
    .req_valid_in, .req_kind_in, .req_addr_in, .req_wdata_in, .req_last_in,
    .req_ready_out, .done_out, .rdata_out, .ie_in, .halt_in, .irq_take_out,
    .irq_nmi_out, .irq_vector_out, .int_n_in, .nmi_n_in, .busreq_n_in,
    .busak_n_out, .wait_n_in, .addr_out, .addr_drv_out, .data_in, .data_out,
    .data_drv_out, .opcode_fetch_cycle_out, .mreq_n_out, .mreq_drv_out,
    .ioreq_n_out, .ioreq_drv_out, .rd_n_out, .rd_drv_out, .wr_n_out,
    .wr_drv_out, .rfsh_n_out, .halt_n_out);
  cbc_mem_model i_cbc_mem_model (.clk_in(clk_in), .resetn_in(resetn_in),
    .addr_in(addr_out), .mreq_n_in(mreq_n_out), .ioreq_n_in(ioreq_n_out),
    .rd_n_in(rd_n_out), .wr_n_in(wr_n_out), .wdata_in(data_out),
    .nwait_in(nwait), .rdata_out(data_in), .wait_n_out(wait_n_in),
    .last_wr_out(last_wr));

  // 200 MHz clock
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end

  // compare and count
  task automatic chk(input string n, input logic [26:0] e, g);
    tests_run++;
    if (e !== g) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // verdict and end of run
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : conclude

  // bounded wait for a level, checked 1 ns after each edge
  task automatic wait_lvl(input string n, ref logic s, input logic v);
    int i;
    i = 0;
    while (s !== v) begin
      @(posedge clk_in);
      #1;
      i++;
      if (i > 300) begin
        chk(n, 27'h0, 27'h1);
        conclude();
      end
    end
  endtask : wait_lvl

  // one machine cycle request; note its expected result
  task automatic cyc(input int k, input logic [15:0] a,
      input logic [7:0] d, input logic last, input logic [1:0] nw);
    logic w;
    // let an edge pass so valid never toggles twice in one step
    @(posedge clk_in);
    #1 w = (k == 2) || (k == 4);
    req_kind_in = cbc_pkg::cbc_kind_t'(k[2:0]);
    req_addr_in = a;
    req_wdata_in = d;
    req_last_in = last;
    req_valid_in = 1'b1;
    exp_q.push_back({w, k == 0 || k == 5, k >= 3, a, w ? d : a[7:0] ^ 8'h3C});
    wait_lvl("ready", req_ready_out, 1'b1);
    @(posedge clk_in);
    #1;
    req_valid_in = 1'b0;
    nwait = nw;
  endtask : cyc

  // bounded wait until all noted cycles completed
  task automatic drain;
    for (int i = 0; i < 300 && exp_q.size() != 0; i++) @(posedge clk_in);
    chk("drain", 27'h0, 27'(exp_q.size()));
    if (exp_q.size() != 0) conclude();
    #1;
  endtask : drain

  // watcher: compares each completed cycle and each interrupt take
  always @(posedge clk_in) begin
    if (rd_n_out === 1'b0 || wr_n_out === 1'b0)
      seen <= {!wr_n_out, opcode_fetch_cycle_out, !ioreq_n_out, addr_out};
    if (done_out === 1'b1) begin
      if (exp_q.size() == 0) chk("done", 27'h0, 27'h1);
      else chk("cycle", exp_q.pop_front(), {seen, seen[18] ? last_wr :
        rdata_out});
    end
    if (irq_take_out === 1'b1) begin
      if (irq_q.size() == 0) chk("take", 27'h0, 27'h1);
      else chk("take", {10'h0, irq_q.pop_front()},
        {10'h0, irq_nmi_out, irq_vector_out});
    end
  end

  // main sequence
  initial begin
    seed = 36;
    {reset_in, req_valid_in, req_last_in, ie_in, halt_in} = 5'h00;
    {int_n_in, nmi_n_in, busreq_n_in} = 3'h7;
    req_kind_in = cbc_pkg::CBC_FETCH;
    {req_addr_in, req_wdata_in, nwait} = 26'h0;
    {miscompares, tests_run} = 64'h0;
    resetn_in = 1'b0;
    repeat (3) @(posedge clk_in);
    #1 resetn_in = 1'b1;
    // every cycle kind against a fast and a slow device
    for (int n = 0; n < 36; n++) begin
      r = $random(seed);
      cyc(n % 6, r[15:0], r[23:16], r[24], r[26:25]);
    end
    drain();
    $display("test cycle kinds done");
    // masked, then enabled maskable request at a boundary
    cyc(1, 16'h0100, 8'h00, 1'b1, 2'h0);
    drain();
    int_n_in = 1'b0;
    repeat (8) @(posedge clk_in);
    #1 irq_q.push_back({1'b0, 16'h0000});
    ie_in = 1'b1;
    wait_lvl("int take", irq_take_out, 1'b1);
    {ie_in, int_n_in} = 2'h1;
    // nmi and maskable raised mid instruction: nmi wins at its end
    cyc(1, 16'h2222, 8'h00, 1'b0, 2'h2);
    {ie_in, int_n_in, nmi_n_in} = 3'h4;
    irq_q.push_back({1'b1, 16'h0066});
    @(posedge clk_in);
    #1 nmi_n_in = 1'b1;
    drain();
    cyc(1, 16'h3333, 8'h00, 1'b1, 2'h1);
    wait_lvl("nmi take", irq_take_out, 1'b1);
    {ie_in, int_n_in} = 2'h1;
    $display("test interrupts done");
    // hold asked during a slow write: granted after it ends
    cyc(2, 16'h4455, 8'hC3, 1'b1, 2'h3);
    busreq_n_in = 1'b0;
    wait_lvl("grant", busak_n_out, 1'b0);
    chk("write before grant", 27'h0, 27'(exp_q.size()));
    repeat (5) @(posedge clk_in);
    #1 chk("ready in hold", 27'h0, {26'h0, req_ready_out});
    busreq_n_in = 1'b1;
    wait_lvl("ungrant", busak_n_out, 1'b1);
    cyc(3, 16'h0077, 8'h00, 1'b1, 2'h0);
    drain();
    $display("test bus hold done");
    // halt until a non-maskable request
    halt_in = 1'b1;
    @(posedge clk_in);
    #1 halt_in = 1'b0;
    wait_lvl("halted", halt_n_out, 1'b0);
    irq_q.push_back({1'b1, 16'h0066});
    nmi_n_in = 1'b0;
    @(posedge clk_in);
    #1 nmi_n_in = 1'b1;
    wait_lvl("resumed", halt_n_out, 1'b1);
    $display("test halt done");
    // external reset needs two high samples
    reset_in = 1'b1;
    @(posedge clk_in);
    #1 chk("one sample", 27'h0, {26'h0, core_rst_out});
    @(posedge clk_in);
    #1 chk("two samples", 27'h1, {26'h0, core_rst_out});
    @(posedge clk_in);
    #1 chk("reset addr", 27'h0, 27'(addr_out));
    reset_in = 1'b0;
    cyc(0, 16'h0010, 8'h00, 1'b1, 2'h1);
    drain();
    $display("test reset done");
    conclude();
  end
endmodule : cbc_bus_ctl_tb
`default_nettype wire
